// ===== core/esh_regs.svh
// Offsets, field positions, field codes and timing counts of the shutdown handshake block.
// Overview of operation
// - Vehicle sends command every 10 ms; byte 2 bits 3-4: 0 normal, 1 shutdown.
// - Decode key position byte 2 bits 7-8: 0,1 no heat, 2 heat, 3 starter.
// - Send acknowledge every 100 ms, priority 3, preheat state byte 2 bits 4-5.
// - Acknowledge byte 2 bit 8: 0 power stays, 1 power may be removed.
// - Acknowledge goes to one only after a requested shutdown has fully completed.
// - A failure stop keeps the acknowledge at zero.
// - A shutdown request stops the engine even after cranking has begun.
`ifndef ESH_REGS_SVH
`define ESH_REGS_SVH
`define ESH_CLK_HZ         50000000
`define ESH_CMD_PERIOD_MS  10
`define ESH_ACK_PERIOD_MS  100
`define ESH_ACK_CYCLES     ((`ESH_CLK_HZ / 1000) * `ESH_ACK_PERIOD_MS)
`define ESH_CMD_CYCLES     ((`ESH_CLK_HZ / 1000) * `ESH_CMD_PERIOD_MS)
`define ESH_ACK_PRIORITY   3'h3
`define ESH_SDREQ_LSB      2
`define ESH_KEY_LSB        6
`define ESH_PREHEAT_LSB    3
`define ESH_SDACK_BIT      7
`define ESH_SDREQ_ACTIVE   2'h1
`define ESH_KEY_HEAT_EN    2'h2
`define ESH_KEY_START      2'h3
`define ESH_PRE_OFF        2'h0
`define ESH_PRE_ON         2'h1
`define ESH_PRE_ERR        2'h2
`define ESH_PRE_NA         2'h3
`define ESH_ADDR_CTRL      12'h000
`define ESH_ADDR_STATUS    12'h004
`define ESH_ADDR_IRQ_STAT  12'h008
`define ESH_ADDR_IRQ_MASK  12'h00C
`define ESH_ADDR_CMD_BYTE  12'h010
`define ESH_IRQ_ACK        0
`define ESH_IRQ_FAIL       1
`define ESH_IRQ_CANCEL     2
`define ESH_IRQ_CMD        3
`endif

// ===== core/esh_pkg.sv
// Types shared by the shutdown handshake block.
package esh_pkg;
  typedef struct packed {
    logic       valid;
    logic [7:0] byte2;
  } esh_cmd_t;
  typedef struct packed {
    logic       valid;
    logic [2:0] priority_lvl;
    logic [7:0] byte2;
  } esh_ack_t;
  typedef enum logic [1:0] {ESH_RUN, ESH_SHUTTING, ESH_DONE, ESH_FAILED} esh_state_t;
endpackage

// ===== core/esh_top.sv
// Shutdown handshake between engine controller and vehicle controller, with APB registers.
//
// Design decisions made here: register access over APB and the placing of the registers.
`timescale 1ns/100ps
`include "esh_regs.svh"
module esh_top
  import esh_pkg::*;
#(
  parameter int ACK_CYCLES = `ESH_ACK_CYCLES
) (
  input  wire logic        sys_clk_in,
  input  wire logic        rst_n_in,
  input  wire esh_cmd_t    cmd_in,
  input  wire logic        shutdown_done_in,
  input  wire logic        failure_stop_in,
  input  wire logic        heater_on_in,
  input  wire logic        heater_fault_in,
  input  wire logic        cranking_in,
  output esh_ack_t         ack_out,
  output logic             engine_stop_out,
  output logic             heat_enable_out,
  output logic             starter_permit_out,
  output logic             irq_out,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr
);
  esh_state_t  state_ff;
  logic [7:0]  cmd_byte_ff;
  logic        cmd_seen_ff;
  logic        sd_ack_ff;
  logic [31:0] tick_ff;
  logic [3:0]  irq_stat_ff;
  logic [3:0]  irq_mask_ff;
  logic        force_stop_ff;
  logic        done_s1_ff, done_s2_ff, fail_s1_ff, fail_s2_ff;
  logic        hon_s1_ff, hon_s2_ff, hflt_s1_ff, hflt_s2_ff;
  logic        crank_s1_ff, crank_s2_ff;
  logic [3:0]  nxt_events;
  logic        sd_req;
  logic [1:0]  key_pos;
  logic [1:0]  preheat;
  logic        wr_en;
  logic        rd_en;

  function automatic logic [1:0] get_field(input logic [7:0] b, input int lsb);
    get_field = b[lsb +: 2];
  endfunction

  // Status pins come from outside this clock domain.
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      {done_s1_ff, done_s2_ff, fail_s1_ff, fail_s2_ff} <= 4'h0;
      {hon_s1_ff, hon_s2_ff, hflt_s1_ff, hflt_s2_ff}   <= 4'h0;
      {crank_s1_ff, crank_s2_ff}                       <= 2'h0;
    end else begin
      done_s1_ff <= shutdown_done_in;
      done_s2_ff <= done_s1_ff;
      fail_s1_ff <= failure_stop_in;
      fail_s2_ff <= fail_s1_ff;
      hon_s1_ff  <= heater_on_in;
      hon_s2_ff  <= hon_s1_ff;
      hflt_s1_ff <= heater_fault_in;
      hflt_s2_ff <= hflt_s1_ff;
      crank_s1_ff <= cranking_in;
      crank_s2_ff <= crank_s1_ff;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cmd_byte_ff <= 8'h00;
      cmd_seen_ff <= 1'b0;
    end else if (cmd_in.valid) begin
      cmd_byte_ff <= cmd_in.byte2;
      cmd_seen_ff <= 1'b1;
    end
  end

  assign sd_req  = (get_field(cmd_byte_ff, `ESH_SDREQ_LSB) == `ESH_SDREQ_ACTIVE);
  assign key_pos = get_field(cmd_byte_ff, `ESH_KEY_LSB);

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      heat_enable_out    <= 1'b0;
      starter_permit_out <= 1'b0;
    end else begin
      heat_enable_out    <= (key_pos == `ESH_KEY_HEAT_EN);
      starter_permit_out <= (key_pos == `ESH_KEY_START) && !sd_req;
    end
  end

  // Failure wins over completion so a failure stop never reports a clean shutdown.
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_ff <= ESH_RUN;
    end else begin
      unique case (state_ff)
        ESH_RUN: begin
          if (fail_s2_ff) begin
            state_ff <= ESH_FAILED;
          end else if (sd_req) begin
            state_ff <= ESH_SHUTTING;
          end
        end
        ESH_SHUTTING: begin
          if (fail_s2_ff) begin
            state_ff <= ESH_FAILED;
          end else if (!sd_req) begin
            state_ff <= ESH_RUN;
          end else if (done_s2_ff) begin
            state_ff <= ESH_DONE;
          end
        end
        ESH_DONE: begin
          if (!sd_req) begin
            state_ff <= ESH_RUN;
          end
        end
        ESH_FAILED: begin
          if (!fail_s2_ff && !sd_req) begin
            state_ff <= ESH_RUN;
          end
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sd_ack_ff       <= 1'b0;
      engine_stop_out <= 1'b0;
    end else begin
      sd_ack_ff       <= (state_ff == ESH_DONE) && sd_req && !fail_s2_ff;
      engine_stop_out <= sd_req || force_stop_ff;
    end
  end

  assign preheat = hflt_s2_ff ? `ESH_PRE_ERR : (hon_s2_ff ? `ESH_PRE_ON : `ESH_PRE_OFF);

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tick_ff <= 32'h0000_0000;
      ack_out <= '0;
    end else begin
      ack_out.valid <= 1'b0;
      if (tick_ff == 32'(ACK_CYCLES - 1)) begin
        tick_ff              <= 32'h0000_0000;
        ack_out.valid        <= 1'b1;
        ack_out.priority_lvl <= `ESH_ACK_PRIORITY;
        ack_out.byte2        <= 8'h00;
        ack_out.byte2[`ESH_PREHEAT_LSB +: 2] <= preheat;
        ack_out.byte2[`ESH_SDACK_BIT]        <= sd_ack_ff;
      end else begin
        tick_ff <= tick_ff + 32'h0000_0001;
      end
    end
  end

  assign nxt_events[`ESH_IRQ_ACK]    = (state_ff == ESH_SHUTTING) && sd_req && done_s2_ff
                                       && !fail_s2_ff;
  assign nxt_events[`ESH_IRQ_FAIL]   = (state_ff != ESH_FAILED) && fail_s2_ff;
  assign nxt_events[`ESH_IRQ_CANCEL] = (state_ff == ESH_SHUTTING) && !sd_req && !fail_s2_ff;
  assign nxt_events[`ESH_IRQ_CMD]    = cmd_in.valid;

  assign wr_en   = psel && penable && pwrite;
  assign rd_en   = psel && !pwrite;
  assign pready  = 1'b1;
  assign pslverr = 1'b0;

  // Set wins over a write-one clear in the same cycle.
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      irq_stat_ff   <= 4'h0;
      irq_mask_ff   <= 4'h0;
      force_stop_ff <= 1'b0;
    end else begin
      if (wr_en && paddr == `ESH_ADDR_IRQ_STAT) begin
        irq_stat_ff <= (irq_stat_ff & ~pwdata[3:0]) | nxt_events;
      end else begin
        irq_stat_ff <= irq_stat_ff | nxt_events;
      end
      if (wr_en && paddr == `ESH_ADDR_IRQ_MASK) begin
        irq_mask_ff <= pwdata[3:0];
      end
      if (wr_en && paddr == `ESH_ADDR_CTRL) begin
        force_stop_ff <= pwdata[0];
      end
    end
  end

  assign irq_out = |(irq_stat_ff & irq_mask_ff);

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      prdata <= 32'h0000_0000;
    end else if (rd_en && !penable) begin
      unique case (paddr)
        `ESH_ADDR_CTRL:     prdata <= {31'h0, force_stop_ff};
        `ESH_ADDR_STATUS:   prdata <= {24'h0, cmd_seen_ff, crank_s2_ff, preheat,
                                       sd_ack_ff, sd_req, 2'(state_ff)};
        `ESH_ADDR_IRQ_STAT: prdata <= {28'h0, irq_stat_ff};
        `ESH_ADDR_IRQ_MASK: prdata <= {28'h0, irq_mask_ff};
        `ESH_ADDR_CMD_BYTE: prdata <= {24'h0, cmd_byte_ff};
        default:            prdata <= 32'h0000_0000;
      endcase
    end
  end

  a_ack_needs_req: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    $rose(sd_ack_ff) |-> $past(state_ff) == ESH_DONE && $past(sd_req))
    else $error("Acknowledge rose without completed shutdown.");
  a_fail_no_ack: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    state_ff == ESH_FAILED |=> !sd_ack_ff)
    else $error("Acknowledge set after failure stop.");
  a_cancel_abandon: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    state_ff == ESH_SHUTTING && !sd_req && !fail_s2_ff |=> state_ff == ESH_RUN ##1 !sd_ack_ff)
    else $error("Withdrawn request not abandoned.");
  a_stop_on_req: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    sd_req |=> engine_stop_out)
    else $error("Engine not stopped on request.");
  a_ack_frame: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    ack_out.valid |-> ack_out.priority_lvl == 3'h3 && ack_out.byte2[7] == $past(sd_ack_ff))
    else $error("Acknowledge frame contents wrong.");
  a_preheat_code: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    ack_out.valid |-> ack_out.byte2[4:3] == $past(preheat))
    else $error("Preheat code wrong in frame.");
  a_key_decode: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    key_pos == 2'h2 |=> heat_enable_out && !starter_permit_out)
    else $error("Key position decode wrong.");
  a_req_decode: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    cmd_in.valid && cmd_in.byte2[3:2] == 2'h1 |=> sd_req)
    else $error("Shutdown request not decoded.");
endmodule

// ===== verif/esh_vehicle_model.sv
// Vehicle controller model that sends the command group at a fixed period.
`timescale 1ns/100ps
module esh_vehicle_model
  import esh_pkg::*;
#(
  parameter int PERIOD = 8
) (
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  input  wire logic [7:0] byte2_in,
  output esh_cmd_t        cmd_out
);
  int tick_ff;
  // Between frames the byte is inverted, so stale data never looks like a frame.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tick_ff <= 0;
      cmd_out <= '0;
    end else begin
      tick_ff <= (tick_ff == PERIOD - 1) ? 0 : tick_ff + 1;
      cmd_out.valid <= (tick_ff == PERIOD - 1);
      cmd_out.byte2 <= (tick_ff == PERIOD - 1) ? byte2_in : ~byte2_in;
    end
  end
endmodule

// ===== verif/engine_shutdown_handshake_bench.sv
// Self-checking bench for the shutdown handshake block.
`timescale 1ns/100ps
`include "esh_regs.svh"
module engine_shutdown_handshake_bench
  import esh_pkg::*;
;
  logic        sys_clk_in = 1'b0;
  logic        rst_n_in = 1'b0;
  logic        done, fail, hon, hflt, crank, stop, heat, start, irq, err;
  logic        psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [31:0] seed = 32'hF985;
  logic [7:0]  byte2;
  logic [1:0]  pre;
  esh_cmd_t    cmd;
  esh_ack_t    ack;
  int          failures, comparisons, cyc, n;

  always #10 sys_clk_in = ~sys_clk_in;

  esh_vehicle_model #(.PERIOD(8)) i_vehicle (.clk_in(sys_clk_in), .rst_n_in(rst_n_in),
    .byte2_in(byte2), .cmd_out(cmd));
  esh_top #(.ACK_CYCLES(20)) i_dut (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
    .cmd_in(cmd), .shutdown_done_in(done), .failure_stop_in(fail), .heater_on_in(hon),
    .heater_fault_in(hflt), .cranking_in(crank), .ack_out(ack), .engine_stop_out(stop),
    .heat_enable_out(heat), .starter_permit_out(start), .irq_out(irq), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic end_sim();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // The request is held until pready is seen high, however long that takes.
  task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] d);
    @(posedge sys_clk_in);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= d;
    @(posedge sys_clk_in);
    penable <= 1'b1;
    do @(posedge sys_clk_in); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic frame();
    do @(negedge sys_clk_in); while (ack.valid !== 1'b1);
  endtask

  // Three acknowledge frames cover command period, input sync and state update.
  task automatic run(input logic [7:0] b, input logic d, input logic f);
    @(posedge sys_clk_in);
    byte2 <= b;
    done <= d;
    fail <= f;
    repeat (3) frame();
  endtask

  always @(posedge sys_clk_in) begin
    cyc++;
    if (cyc == 6000) begin
      failures++;
      end_sim();
    end
  end

  initial begin
    {done, fail, hon, hflt, crank, psel, penable, pwrite, paddr, pwdata} = '0;
    byte2 = 8'h00;
    repeat (10) @(posedge sys_clk_in);
    rst_n_in <= 1'b1;
    for (int k = 0; k < 8; k++) begin
      @(posedge sys_clk_in);
      {hon, hflt} <= 2'(rnd());
      // Key position sits in the top two bits; the request field stays clear.
      run({k[1:0], 6'(rnd()) & 6'h33}, 1'b0, 1'b0);
      pre = hflt ? `ESH_PRE_ERR : (hon ? `ESH_PRE_ON : `ESH_PRE_OFF);
      check(heat, k[1:0] == `ESH_KEY_HEAT_EN, "heat");
      check(start, k[1:0] == `ESH_KEY_START, "start");
      check(ack.byte2, {3'h0, pre, 3'h0}, "ack byte");
      check(ack.priority_lvl, 3'h3, "priority");
    end
    n = cyc;
    frame();
    check(cyc - n, 20, "ack period");
    $display("key and preheat test done");
    @(posedge sys_clk_in);
    {hon, hflt, crank} <= 3'b001;
    apb(1'b1, `ESH_ADDR_IRQ_STAT, 32'h0000000F);
    run(8'hC4, 1'b0, 1'b0);
    check({stop, start, ack.byte2[7]}, 3'b100, "crank stop");
    run(8'hC4, 1'b1, 1'b0);
    check(ack.byte2[7], 1'b1, "ack done");
    apb(1'b0, `ESH_ADDR_STATUS, 32'h0);
    check(rd[7:0], 8'hCE, "status");
    apb(1'b0, `ESH_ADDR_CMD_BYTE, 32'h0);
    check(rd, 32'h000000C4, "command byte");
    apb(1'b0, `ESH_ADDR_IRQ_STAT, 32'h0);
    check(rd[0], 1'b1, "irq ack");
    apb(1'b1, `ESH_ADDR_IRQ_MASK, 32'h0);
    @(negedge sys_clk_in);
    check(irq, 1'b0, "irq masked");
    apb(1'b1, `ESH_ADDR_IRQ_MASK, 32'h00000001);
    @(negedge sys_clk_in);
    check(irq, 1'b1, "irq mask");
    apb(1'b1, `ESH_ADDR_IRQ_STAT, 32'h00000001);
    @(negedge sys_clk_in);
    check(irq, 1'b0, "irq dropped");
    apb(1'b0, `ESH_ADDR_IRQ_STAT, 32'h0);
    check(rd[0], 1'b0, "irq clear");
    apb(1'b0, 12'h020, 32'h0);
    check(rd, 32'h0, "unmapped");
    check(err, 1'b0, "slave error");
    $display("shutdown test done");
    run(8'h00, 1'b0, 1'b0);
    run(8'h04, 1'b0, 1'b0);
    run(8'h00, 1'b0, 1'b0);
    apb(1'b0, `ESH_ADDR_STATUS, 32'h0);
    check(rd[1:0], 2'h0, "abandoned");
    run(8'h00, 1'b1, 1'b0);
    check(ack.byte2[7], 1'b0, "withdrawn");
    check(stop, 1'b0, "no stop");
    apb(1'b0, `ESH_ADDR_IRQ_STAT, 32'h0);
    check(rd[2], 1'b1, "irq cancel");
    apb(1'b1, `ESH_ADDR_CTRL, 32'h00000001);
    apb(1'b0, `ESH_ADDR_CTRL, 32'h0);
    check({rd[0], stop}, 2'b11, "forced stop");
    apb(1'b1, `ESH_ADDR_CTRL, 32'h0);
    run(8'h04, 1'b0, 1'b1);
    run(8'h04, 1'b1, 1'b1);
    check(ack.byte2[7], 1'b0, "failure stop");
    apb(1'b0, `ESH_ADDR_IRQ_STAT, 32'h0);
    check(rd[1], 1'b1, "irq failure");
    $display("cancel and failure test done");
    end_sim();
  end
endmodule
